// ==== bench/lbtm_far_end.sv ====
// Far-end model: controller transmit pins and line receive path
`timescale 1ns/1ps
module lbtm_far_end (
   input  wire logic hclk,             // Clock
   input  wire logic tx_on,            // Controller sends a frame
   input  wire logic line_on,          // Line frame present
   output logic      tx_data,          // Transmit data
   output logic      tx_clk,           // Transmit clock
   output logic      transmit_request, // Transmit enable
   output logic      line_data,        // Line data
   output logic      line_clk,         // Line clock
   output logic      line_active       // Line activity
);
   logic [3:0] cnt_ff = 4'h0;
   always_ff @(posedge hclk)
      cnt_ff <= cnt_ff + 4'h1;
   // ==========================================================
   // Pins; clocks stop and data scrambles outside frames
   always_comb
   begin
      transmit_request = tx_on;
      tx_clk = tx_on & cnt_ff[0];
      tx_data = tx_on ? cnt_ff[2] : ~cnt_ff[1];
      line_active = line_on;
      line_clk = line_on & cnt_ff[0];
      line_data = line_on ? cnt_ff[1] : ~cnt_ff[2];
   end
endmodule : lbtm_far_end

// ==== bench/tb_top.sv ====
// Self-checking testbench of the loopback and test-mode block
`timescale 1ns/1ps
module tb_top
   import lbtm_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000, hrdata, q;
   logic hready, hresp, tx_data, tx_clk, transmit_request;
   logic line_data, line_clk, line_active, rx_data_ff, rx_clk_ff;
   logic receive_active, collision_ff, line_tx_en_ff, test_mode_ff;
   logic dev_reset_ff, tx_on = 1'b0, line_on = 1'b0;
   int mismatches = 0, cmp_count = 0;
   initial forever #20 hclk = ~hclk;
   lbtm_far_end u_far (.hclk(hclk), .tx_on(tx_on), .line_on(line_on),
      .tx_data(tx_data), .tx_clk(tx_clk), .transmit_request(transmit_request),
      .line_data(line_data), .line_clk(line_clk), .line_active(line_active));
   lbtm_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .tx_data(tx_data), .tx_clk(tx_clk), .transmit_request(transmit_request),
      .line_data(line_data), .line_clk(line_clk), .line_active(line_active),
      .rx_data_ff(rx_data_ff), .rx_clk_ff(rx_clk_ff),
      .receive_active(receive_active), .collision_ff(collision_ff),
      .line_tx_en_ff(line_tx_en_ff), .test_mode_ff(test_mode_ff),
      .dev_reset_ff(dev_reset_ff));
   // ==========================================================
   // Helpers
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         mismatches++;
      end
   endtask : chk
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 50)
      begin
         @(posedge hclk);
         n++;
      end
      if (n >= 50)
      begin
         mismatches++;
         report_and_stop;
      end
   endtask : wait_rdy
   // Address phase held until ready, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      q = hrdata;
   endtask : bus
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(n, e, q);
   endtask : rd
   task automatic wr(input logic [31:0] d);
      bus(1'b1, LBTM_CTRL_OFS, d);
      repeat (3) @(negedge hclk);
   endtask : wr
   // Receive outputs trail a source by one cycle
   task automatic follow(input logic lp);
      logic p, c;
      @(negedge hclk);
      p = lp ? tx_data : line_data;
      c = lp ? tx_clk : line_clk;
      repeat (8)
      begin
         @(negedge hclk);
         chk("rx_data", p, rx_data_ff);
         chk("rx_clk", c, rx_clk_ff);
         p = lp ? tx_data : line_data;
         c = lp ? tx_clk : line_clk;
      end
   endtask : follow
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      rd("ctrl", LBTM_CTRL_OFS, 32'h0000_0000);
      bus(1'b1, LBTM_STAT_OFS, 32'hFFFF_FFFF);
      rd("stat", LBTM_STAT_OFS, 32'h0000_0000);
      rd("treg", LBTM_TREG_OFS, 32'h0000_0000);
      rd("unmapped", 8'h20, 32'h0000_0000);
   endtask : t_regs
   task automatic t_loop;
      tx_on <= 1'b1;
      line_on <= 1'b1;
      wr(32'h0000_0001);
      follow(1'b1);
      chk("rx_en", transmit_request, receive_active);
      chk("line_tx", 1'b0, line_tx_en_ff);
   endtask : t_loop
   task automatic t_fdx;
      wr(32'h0000_0002);
      follow(1'b0);
      chk("collision", 1'b0, collision_ff);
      chk("test", 1'b0, test_mode_ff);
   endtask : t_fdx
   task automatic t_test;
      wr(32'h0000_0007);
      chk("test", 1'b1, test_mode_ff);
      chk("rx_data", 1'b0, rx_data_ff);
      chk("rx_en", 1'b0, receive_active);
      chk("line_tx", 1'b0, line_tx_en_ff);
      repeat (10) @(posedge hclk);
      rd("treg_ones", LBTM_TREG_OFS, 32'h0000_00FF);
      wr(32'h0000_0003);
      repeat (10) @(posedge hclk);
      rd("treg_zero", LBTM_TREG_OFS, 32'h0000_0000);
   endtask : t_test
   task automatic t_recover;
      int n;
      // full recovery before relying on the part
      wr(32'h0000_0002);
      chk("test_off", 1'b0, test_mode_ff);
      wr(32'h0000_0003);
      // wait counted in clocks, shortened to keep the run brief
      repeat (20) @(posedge hclk);
      bus(1'b1, LBTM_CTRL_OFS, 32'h0000_0001);
      n = 0;
      repeat (12)
      begin
         @(negedge hclk);
         n += (dev_reset_ff === 1'b1);
      end
      chk("rst_len", RST_PULSE_CYC, n);
      chk("test_held", 1'b1, test_mode_ff);
      rd("stat_seen", LBTM_STAT_OFS, 32'h0000_0015);
      wr(32'h0000_0000);
      chk("test_exit", 1'b0, test_mode_ff);
      chk("collision", 1'b1, collision_ff);
      chk("line_tx_on", 1'b1, line_tx_en_ff);
      rd("stat_norm", LBTM_STAT_OFS, 32'h0000_0000);
   endtask : t_recover
   // ==========================================================
   // Main sequence and watchdog
   initial
   begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_loop;
      t_fdx;
      t_test;
      t_recover;
      report_and_stop;
   end
   initial
   begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      report_and_stop;
   end
endmodule : tb_top

// ==== verilog/lbtm_ctrl.sv ====
// Loopback, full-duplex and test-mode recovery logic with AHB-Lite registers
`timescale 1ns/1ps
module lbtm_ctrl
   import lbtm_pkg::*;
(
   input  wire logic        hclk,          // Bus and device clock
   input  wire logic        hresetn,       // Async reset, active low
   input  wire logic        hsel,          // Slave select
   input  wire logic [7:0]  haddr,         // Byte address
   input  wire logic [1:0]  htrans,        // Transfer type
   input  wire logic        hwrite,        // Write strobe
   input  wire logic [2:0]  hsize,         // Transfer size
   input  wire logic        hready,        // Bus ready
   input  wire logic [31:0] hwdata,        // Write data
   output logic [31:0]      hrdata,        // Read data
   output logic             hreadyout,     // Slave ready
   output logic             hresp,         // Response, always OKAY
   input  wire logic        tx_data,       // Encoded transmit data
   input  wire logic        tx_clk,        // Transmit clock, sampled
   input  wire logic        transmit_request, // Transmit enable
   input  wire logic        line_data,     // Decoded data from line
   input  wire logic        line_clk,      // Recovered clock from line
   input  wire logic        line_active,   // Valid line activity
   output logic             rx_data_ff,    // Receive data to controller
   output logic             rx_clk_ff,     // Receive clock to controller
   output logic             receive_active,// Receive enable
   output logic             collision_ff,  // Collision indication
   output logic             line_tx_en_ff, // Drive transmitter onto line
   output logic             test_mode_ff,  // Production test mode
   output logic             dev_reset_ff   // Internal reset pulse
);
   typedef enum logic [1:0] {
      LBTM_IDLE = 2'b00,
      LBTM_READ = 2'b01,
      LBTM_WRT  = 2'b10
   } lbtm_bus_t;

   logic [2:0]        ctrl_ff, nxt_ctrl;
   logic [7:0]        addr_ff, nxt_addr;
   lbtm_bus_t         bus_ff, nxt_bus;
   logic [31:0]       nxt_hrdata;
   logic              loop_sel, fdx_sel, hbt_sel;
   logic              fdx_prev_ff, nxt_fdx_prev;
   logic              nxt_test, nxt_devrst;
   logic              rst_seen_ff, nxt_rst_seen;
   logic [3:0]        rcnt_ff, nxt_rcnt;
   logic              nxt_rxd, nxt_rxc, nxt_receive_active, nxt_col, nxt_ltx;
   logic [TREG_W-1:0] treg;
   logic [31:0]       stat_word;

   assign loop_sel = ctrl_ff[CTRL_LOOP_BIT];
   assign fdx_sel  = ctrl_ff[CTRL_FDX_BIT];
   assign hbt_sel  = ctrl_ff[CTRL_HBT_BIT];

   // ==========================================================
   // AHB-Lite slave, zero wait states
   always_comb
   begin
      nxt_bus  = LBTM_IDLE;
      nxt_addr = addr_ff;
      if (hsel && hready && htrans[1])
      begin
         nxt_addr = haddr;
         nxt_bus  = hwrite ? LBTM_WRT : LBTM_READ;
      end
   end

   always_comb
   begin
      stat_word = 32'h0000_0000;
      stat_word[STAT_TEST_BIT]    = test_mode_ff;
      stat_word[STAT_FDX_BIT]     = fdx_sel;
      stat_word[STAT_LOOP_BIT]    = loop_sel;
      stat_word[STAT_RST_BIT]     = dev_reset_ff;
      stat_word[STAT_RSTSEEN_BIT] = rst_seen_ff;
      nxt_hrdata = 32'h0000_0000;
      if (nxt_bus == LBTM_READ)
      begin
         unique case (haddr)
            LBTM_CTRL_OFS: nxt_hrdata = {29'h0000_0000, ctrl_ff};
            LBTM_STAT_OFS: nxt_hrdata = stat_word;
            LBTM_TREG_OFS: nxt_hrdata = {24'h00_0000, treg};
            default:       nxt_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      if (bus_ff == LBTM_WRT && addr_ff == LBTM_CTRL_OFS)
         nxt_ctrl = hwdata[2:0];
   end

   // ==========================================================
   // Mode decode and recovery sequencing
   always_comb
   begin
      nxt_fdx_prev = fdx_sel;
      nxt_test = loop_sel && fdx_sel;
      nxt_devrst = 1'b0;
      nxt_rcnt = rcnt_ff;
      nxt_rst_seen = rst_seen_ff;
      if (fdx_prev_ff && !fdx_sel && loop_sel && !hbt_sel)
      begin
         nxt_rcnt = RST_PULSE_CNT;
         nxt_rst_seen = 1'b1;
         // Hold test mode in the fall cycle too, else looped traffic slips out
         nxt_test = 1'b1;
      end
      else if (rcnt_ff != 4'h0)
         nxt_rcnt = rcnt_ff - 4'h1;
      if (nxt_rcnt != 4'h0)
         nxt_devrst = 1'b1;
      // stays in test mode after reset until loop drops
      if (rst_seen_ff && loop_sel)
         nxt_test = 1'b1;
      if (!loop_sel)
         nxt_rst_seen = 1'b0;
   end

   // ==========================================================
   // Data path
   always_comb
   begin
      nxt_rxd = 1'b0;
      nxt_rxc = 1'b0;
      nxt_receive_active = 1'b0;
      nxt_col = 1'b0;
      nxt_ltx = 1'b0;
      if (nxt_test)
      begin
         nxt_rxd = 1'b0;
      end
      else if (loop_sel && !fdx_sel)
      begin
         // uses encoded path, line kept quiet
         nxt_rxd  = tx_data;
         nxt_rxc  = tx_clk;
         nxt_receive_active = transmit_request;
      end
      else
      begin
         nxt_rxd  = line_active ? line_data : 1'b0;
         nxt_rxc  = line_active ? line_clk : 1'b0;
         nxt_receive_active = line_active;
         nxt_ltx  = transmit_request;
         nxt_col  = !fdx_sel && transmit_request && line_active;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_ff       <= CTRL_RESET_VAL;
         addr_ff       <= 8'h00;
         bus_ff        <= LBTM_IDLE;
         hrdata        <= 32'h0000_0000;
         fdx_prev_ff   <= 1'b0;
         test_mode_ff  <= 1'b0;
         dev_reset_ff  <= 1'b0;
         rst_seen_ff   <= 1'b0;
         rcnt_ff       <= 4'h0;
         rx_data_ff    <= 1'b0;
         rx_clk_ff     <= 1'b0;
         receive_active <= 1'b0;
         collision_ff  <= 1'b0;
         line_tx_en_ff <= 1'b0;
      end
      else
      begin
         ctrl_ff       <= nxt_ctrl;
         addr_ff       <= nxt_addr;
         bus_ff        <= nxt_bus;
         hrdata        <= nxt_hrdata;
         fdx_prev_ff   <= nxt_fdx_prev;
         test_mode_ff  <= nxt_test;
         dev_reset_ff  <= nxt_devrst;
         rst_seen_ff   <= nxt_rst_seen;
         rcnt_ff       <= nxt_rcnt;
         rx_data_ff    <= nxt_rxd;
         rx_clk_ff     <= nxt_rxc;
         receive_active <= nxt_receive_active;
         collision_ff  <= nxt_col;
         line_tx_en_ff <= nxt_ltx;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   lbtm_test_reg u_treg
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .test_mode (test_mode_ff),
      .soft_rst  (dev_reset_ff),
      .hbt_in    (hbt_sel),
      .treg_ff   (treg)
   );

   // ==========================================================
   // Checks
   a_test_entry: assert property (@(posedge hclk) disable iff (!hresetn)
      (loop_sel && fdx_sel) |=> test_mode_ff && !line_tx_en_ff && !receive_active)
      else $error("test mode not entered");
   a_loop_path: assert property (@(posedge hclk) disable iff (!hresetn)
      (loop_sel && !fdx_sel && !rst_seen_ff && !($fell(fdx_sel) && !hbt_sel))
         |=> rx_data_ff == $past(tx_data)
         && rx_clk_ff == $past(tx_clk))
      else $error("loopback data mismatch");
   a_loop_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
      (loop_sel && !fdx_sel) |=> !line_tx_en_ff)
      else $error("line driven in loopback");
   a_reset_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
      ($fell(fdx_sel) && loop_sel && !hbt_sel) |=> dev_reset_ff[*5] ##1 !dev_reset_ff)
      else $error("reset pulse wrong length");
   a_reset_test: assert property (@(posedge hclk) disable iff (!hresetn)
      ($fell(fdx_sel) && loop_sel && !hbt_sel) |=> test_mode_ff && dev_reset_ff)
      else $error("test mode dropped at reset");
   a_hold_test: assert property (@(posedge hclk) disable iff (!hresetn)
      (rst_seen_ff && loop_sel) |=> test_mode_ff)
      else $error("test mode left early");
   a_exit_test: assert property (@(posedge hclk) disable iff (!hresetn)
      (!loop_sel) |=> !test_mode_ff)
      else $error("test mode not left");
   a_treg_load: assert property (@(posedge hclk) disable iff (!hresetn)
      (test_mode_ff && !dev_reset_ff) |=> treg[0] == $past(hbt_sel))
      else $error("test register not loaded");
   a_fdx_nocol: assert property (@(posedge hclk) disable iff (!hresetn)
      fdx_sel |=> !collision_ff)
      else $error("collision in full duplex");
   a_line_rx: assert property (@(posedge hclk) disable iff (!hresetn)
      (!loop_sel && !line_active) |=> !receive_active)
      else $error("receive without line activity");
   c_loop: cover property (@(posedge hclk) disable iff (!hresetn)
      loop_sel && !fdx_sel && transmit_request);
   c_reset: cover property (@(posedge hclk) disable iff (!hresetn) $rose(dev_reset_ff));
   c_exit: cover property (@(posedge hclk) disable iff (!hresetn) $fell(test_mode_ff));
endmodule : lbtm_ctrl

// ==== verilog/lbtm_pkg.sv ====
// Package of constants for the loopback and test-mode recovery block
package lbtm_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0]  LBTM_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  LBTM_STAT_OFS   = 8'h04;
   localparam logic [7:0]  LBTM_TREG_OFS   = 8'h08;
   // Control fields
   localparam int          CTRL_LOOP_BIT   = 0;
   localparam int          CTRL_FDX_BIT    = 1;
   localparam int          CTRL_HBT_BIT    = 2;
   localparam logic [2:0]  CTRL_RESET_VAL  = 3'h0;
   // Status fields
   localparam int          STAT_TEST_BIT   = 0;
   localparam int          STAT_FDX_BIT    = 1;
   localparam int          STAT_LOOP_BIT   = 2;
   localparam int          STAT_RST_BIT    = 3;
   localparam int          STAT_RSTSEEN_BIT = 4;
   // Test register
   localparam int          TREG_W          = 8;
   localparam logic [7:0]  TREG_RESET_VAL  = 8'h00;
   // ==========================================================
   // Timing
   localparam int          CLK_HZ          = 25_000_000;
   localparam int          RST_PULSE_NS    = 200;
   localparam int          CLK_NS          = 40;
   localparam int          RST_PULSE_CYC   = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0]  RST_PULSE_CNT   = 4'(RST_PULSE_CYC);
endpackage : lbtm_pkg

// ==== verilog/lbtm_test_reg.sv ====
// Internal production test register, loaded while in test mode
`timescale 1ns/1ps
module lbtm_test_reg
   import lbtm_pkg::*;
(
   input  wire logic              hclk,        // Clock
   input  wire logic              hresetn,     // Async reset, active low
   input  wire logic              test_mode,   // Test mode active
   input  wire logic              soft_rst,    // Internal reset pulse
   input  wire logic              hbt_in,      // Heartbeat-test enable level
   output logic [TREG_W-1:0]      treg_ff      // Register contents
);
   logic [TREG_W-1:0] nxt_treg;

   // ==========================================================
   // Shift in the serial level
   always_comb
   begin
      nxt_treg = treg_ff;
      if (soft_rst)
         nxt_treg = TREG_RESET_VAL;
      else if (test_mode)
         nxt_treg = {treg_ff[TREG_W-2:0], hbt_in};
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         treg_ff <= TREG_RESET_VAL;
      else
         treg_ff <= nxt_treg;
   end
endmodule : lbtm_test_reg
